// ### sbc_pkg.sv
// Shared constants and types of the wake-up and serial control block
package sbc_pkg;
  // Operating modes driven in by the mode controller
  typedef enum logic [1:0] {
    SBC_MODE_RESET,
    SBC_MODE_NORMAL,
    SBC_MODE_SLEEP,
    SBC_MODE_STOP
  } sbc_mode_t;
  // Serial word width and bit counter width
  localparam int SBC_WORD_W = 8;
  localparam int SBC_CNT_W = 3;
  // Command word field positions
  localparam int SBC_CMD_HS1 = 0;
  localparam int SBC_CMD_HS2 = 1;
  localparam int SBC_CMD_HS3 = 2;
  // Status word field positions
  localparam int SBC_ST_LVL1 = 0;
  localparam int SBC_ST_LVL2 = 1;
  localparam int SBC_ST_WAKE_LVL = 6;
  localparam int SBC_ST_WAKE_LIN = 7;
  // Synchroniser lane positions
  localparam int SBC_SY_CS = 0;
  localparam int SBC_SY_TOG = 1;
  localparam int SBC_SY_LVL1 = 2;
  localparam int SBC_SY_LVL2 = 3;
  localparam int SBC_SY_LIN = 4;
  localparam int SBC_SY_TXD = 5;
  localparam int SBC_SY_GATE = 6;
  localparam int SBC_SY_WDP = 7;
  localparam int SBC_SY_WDR = 8;
  localparam int SBC_SY_W = 9;
  // Reset values
  localparam logic [7:0] SBC_CMD_RST = 8'h00;
  // Lanes reset to their idle level; the word toggle idles low
  localparam logic [8:0] SBC_SYNC_RST = 9'h1FD;
  // Clock rate and timings
  localparam int SBC_CLK_KHZ = 50000;
  localparam int SBC_LIN_FILT_US = 30;
  localparam int SBC_LIN_FILT_CYC = (SBC_LIN_FILT_US * SBC_CLK_KHZ + 999) / 1000;
  localparam int SBC_WAKE_DLY_CYC = 2;
  localparam int SBC_INT_US = 10;
  localparam int SBC_INT_CYC = (SBC_INT_US * SBC_CLK_KHZ) / 1000;
  localparam int SBC_WD_DEFAULT_MS = 150;
  localparam int SBC_TMR_W = 11;
endpackage : sbc_pkg

// ### sbc_spi_if.sv
// Carrier between the serial shifter and the control core
`timescale 1ns/1ps
`default_nettype none
interface sbc_spi_if;
  logic [7:0] rx_word; // Last complete received word
  logic rx_toggle; // Flips once per complete word
  logic [7:0] tx_word; // Status word, frozen during a frame
  logic miso; // Serial output data
  logic miso_oe; // Serial output enable
  modport shifter (output rx_word, output rx_toggle, input tx_word,
    output miso, output miso_oe);
  modport core (input rx_word, input rx_toggle, output tx_word,
    input miso, input miso_oe);
endinterface : sbc_spi_if
`default_nettype wire

// ### sbc_spi_shift.sv
// Serial shifter running on the link clock
`timescale 1ns/1ps
`default_nettype none
module sbc_spi_shift (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic rst,
  sbc_spi_if.shifter bus
);
  logic [6:0] shift_reg; // Partial received bits
  logic [2:0] bit_cnt_reg; // Received bit count
  logic [2:0] tx_cnt_reg; // Transmitted bit count
  logic [7:0] rx_word_reg; // Completed word
  logic rx_toggle_reg; // Word event toggle
  logic miso_reg; // Output data flop
  logic oe_reg; // Output enable flop

  // Capture on rising edge, held clear while deselected
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      shift_reg <= 7'h00;
      bit_cnt_reg <= 3'h0;
    end else begin
      shift_reg <= {shift_reg[5:0], mosi};
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // Publish only a whole eight-bit word
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      rx_word_reg <= 8'h00;
      rx_toggle_reg <= 1'b0;
    end else if (!cs_n && bit_cnt_reg == 3'h7) begin
      rx_word_reg <= {shift_reg, mosi};
      rx_toggle_reg <= ~rx_toggle_reg;
    end
  end

  // Output bits change on falling edge, released when deselected
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      tx_cnt_reg <= 3'h0;
      miso_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      miso_reg <= bus.tx_word[3'h7 - tx_cnt_reg];
      tx_cnt_reg <= tx_cnt_reg + 3'h1;
      oe_reg <= 1'b1;
    end
  end

  assign bus.rx_word = rx_word_reg;
  assign bus.rx_toggle = rx_toggle_reg;
  assign bus.miso = miso_reg;
  assign bus.miso_oe = oe_reg;
endmodule : sbc_spi_shift
`default_nettype wire

// ### sbc_core.sv
// Control core: switch gating, level inputs, wake-up and pin decoding
`timescale 1ns/1ps
`default_nettype none
module sbc_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire sbc_pkg::sbc_mode_t mode,
  input wire logic level_input_one,
  input wire logic level_input_two,
  input wire logic pwm_gate,
  output logic high_side_out_one,
  output logic high_side_out_two,
  output logic high_side_out_three,
  input wire logic lin_bus_in,
  output logic lin_bus_out,
  output logic lin_bus_oe,
  input wire logic lin_txd,
  output logic lin_rxd,
  output logic wake_req,
  output logic int_n,
  output logic amp_en,
  input wire logic watchdog_period_pin,
  input wire logic watchdog_resistor_fitted,
  output logic wd_enable,
  output logic wd_use_default
);
  // Link between shifter and core
  sbc_spi_if spi ();

  // Pin samples gathered into one vector
  logic [sbc_pkg::SBC_SY_W-1:0] pin_raw;
  // First synchroniser stage, read only by the second
  logic [sbc_pkg::SBC_SY_W-1:0] sync1_reg;
  // Second synchroniser stage, safe to use
  logic [sbc_pkg::SBC_SY_W-1:0] sync2_reg;
  // Delayed copy for edge detection
  logic [sbc_pkg::SBC_SY_W-1:0] sync3_reg;

  // Latched command word
  logic [7:0] cmd_reg;
  // Frozen status word seen by the shifter
  logic [7:0] tx_reg;
  // Sticky wake flags
  logic wake_lvl_reg;
  logic wake_lin_reg;
  // Command word arrived this cycle
  logic word_evt;
  // Mode helpers
  logic low_power;
  logic in_normal;
  // LIN dominant duration counter
  logic [sbc_pkg::SBC_TMR_W-1:0] dom_cnt_reg;
  // Dominant phase long enough to count
  logic dom_ok_reg;
  // Delay line for wake reporting
  logic [sbc_pkg::SBC_WAKE_DLY_CYC-1:0] wdly_reg;
  // LIN wake detected this cycle
  logic lin_edge_ok;
  // Level change detected this cycle
  logic lvl_change;
  // Interrupt pulse timer
  logic [sbc_pkg::SBC_TMR_W-1:0] int_cnt_reg;
  // Registered outputs
  logic hs1_reg;
  logic hs2_reg;
  logic hs3_reg;
  logic rxd_reg;
  logic lin_oe_reg;
  logic wake_reg;
  logic int_n_reg;
  logic amp_reg;
  logic wd_en_reg;
  logic wd_def_reg;

  // Serial shifter on the link clock
  sbc_spi_shift u_shift (
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .rst(rst),
    .bus(spi)
  );

  // Collect pins and link toggle for crossing
  always_comb begin
    pin_raw = '0;
    pin_raw[sbc_pkg::SBC_SY_CS] = cs_n;
    pin_raw[sbc_pkg::SBC_SY_TOG] = spi.rx_toggle;
    pin_raw[sbc_pkg::SBC_SY_LVL1] = level_input_one;
    pin_raw[sbc_pkg::SBC_SY_LVL2] = level_input_two;
    pin_raw[sbc_pkg::SBC_SY_LIN] = lin_bus_in;
    pin_raw[sbc_pkg::SBC_SY_TXD] = lin_txd;
    pin_raw[sbc_pkg::SBC_SY_GATE] = pwm_gate;
    pin_raw[sbc_pkg::SBC_SY_WDP] = watchdog_period_pin;
    pin_raw[sbc_pkg::SBC_SY_WDR] = watchdog_resistor_fitted;
  end

  // Two-flop synchroniser plus edge stage, one per lane
  genvar gi;
  generate
    for (gi = 0; gi < sbc_pkg::SBC_SY_W; gi = gi + 1) begin : g_sync
      always_ff @(posedge mclk) begin
        if (rst) begin
          sync1_reg[gi] <= sbc_pkg::SBC_SYNC_RST[gi];
          sync2_reg[gi] <= sbc_pkg::SBC_SYNC_RST[gi];
          sync3_reg[gi] <= sbc_pkg::SBC_SYNC_RST[gi];
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
        end
      end
    end
  endgenerate

  // Mode decoding
  assign in_normal = (mode == sbc_pkg::SBC_MODE_NORMAL);
  assign low_power = (mode == sbc_pkg::SBC_MODE_SLEEP) ||
                     (mode == sbc_pkg::SBC_MODE_STOP);

  // A completed word shows as a toggle change
  assign word_evt = sync2_reg[sbc_pkg::SBC_SY_TOG] ^
                    sync3_reg[sbc_pkg::SBC_SY_TOG];

  // Level input change, watched on synchronised copies
  assign lvl_change =
    (sync2_reg[sbc_pkg::SBC_SY_LVL1] ^ sync3_reg[sbc_pkg::SBC_SY_LVL1]) |
    (sync2_reg[sbc_pkg::SBC_SY_LVL2] ^ sync3_reg[sbc_pkg::SBC_SY_LVL2]);

  // Recessive edge after a long enough dominant phase
  assign lin_edge_ok = low_power && dom_ok_reg &&
    sync2_reg[sbc_pkg::SBC_SY_LIN] && !sync3_reg[sbc_pkg::SBC_SY_LIN];

  // Take in command words; partial words never arrive here
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd_reg <= sbc_pkg::SBC_CMD_RST;
    end else if (word_evt) begin
      cmd_reg <= spi.rx_word;
    end
  end

  // Status word frozen while a frame is open
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_reg <= 8'h00;
    end else if (sync2_reg[sbc_pkg::SBC_SY_CS]) begin
      // Idle: refresh the word for the next frame
      tx_reg <= 8'h00;
      if (in_normal) begin
        tx_reg[sbc_pkg::SBC_ST_LVL1] <= sync2_reg[sbc_pkg::SBC_SY_LVL1];
        tx_reg[sbc_pkg::SBC_ST_LVL2] <= sync2_reg[sbc_pkg::SBC_SY_LVL2];
      end
      tx_reg[sbc_pkg::SBC_ST_WAKE_LVL] <= wake_lvl_reg;
      tx_reg[sbc_pkg::SBC_ST_WAKE_LIN] <= wake_lin_reg;
    end
  end
  assign spi.tx_word = tx_reg;

  // Level wake flag, set wins over clear by a word
  always_ff @(posedge mclk) begin
    if (rst) begin
      wake_lvl_reg <= 1'b0;
    end else if (low_power && lvl_change) begin
      wake_lvl_reg <= 1'b1;
    end else if (word_evt) begin
      // Read-out done, flag cleared
      wake_lvl_reg <= 1'b0;
    end
  end

  // LIN wake flag, set wins over clear by a word
  always_ff @(posedge mclk) begin
    if (rst) begin
      wake_lin_reg <= 1'b0;
    end else if (wdly_reg[sbc_pkg::SBC_WAKE_DLY_CYC-1]) begin
      wake_lin_reg <= 1'b1;
    end else if (word_evt) begin
      wake_lin_reg <= 1'b0;
    end
  end

  // Dominant duration measurement for the deglitcher
  always_ff @(posedge mclk) begin
    if (rst) begin
      dom_cnt_reg <= '0;
      dom_ok_reg <= 1'b0;
    end else if (!low_power || sync2_reg[sbc_pkg::SBC_SY_LIN]) begin
      // Recessive or awake: restart measurement
      dom_cnt_reg <= '0;
      dom_ok_reg <= 1'b0;
    end else if (dom_cnt_reg ==
                 sbc_pkg::SBC_TMR_W'(sbc_pkg::SBC_LIN_FILT_CYC - 1)) begin
      // Long enough dominant phase reached
      dom_ok_reg <= 1'b1;
    end else begin
      dom_cnt_reg <= dom_cnt_reg + 1'b1;
    end
  end

  // Two-cycle delay from edge to wake report
  always_ff @(posedge mclk) begin
    if (rst) begin
      wdly_reg <= '0;
    end else begin
      wdly_reg <= {wdly_reg[sbc_pkg::SBC_WAKE_DLY_CYC-2:0],
                   lin_edge_ok};
    end
  end

  // Wake request pulse to the mode controller
  always_ff @(posedge mclk) begin
    if (rst) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= wdly_reg[sbc_pkg::SBC_WAKE_DLY_CYC-1] |
                  (low_power & lvl_change);
    end
  end

  // Interrupt low pulse on LIN wake from Stop
  always_ff @(posedge mclk) begin
    if (rst) begin
      int_cnt_reg <= '0;
      int_n_reg <= 1'b1;
    end else if (wdly_reg[sbc_pkg::SBC_WAKE_DLY_CYC-1] &&
                 mode == sbc_pkg::SBC_MODE_STOP) begin
      // Start the low pulse
      int_cnt_reg <= sbc_pkg::SBC_TMR_W'(sbc_pkg::SBC_INT_CYC - 1);
      int_n_reg <= 1'b0;
    end else if (int_cnt_reg != '0) begin
      // Pulse running
      int_cnt_reg <= int_cnt_reg - 1'b1;
    end else begin
      // Pulse over, release
      int_n_reg <= 1'b1;
    end
  end

  // Switch drives; gate held high by the host without PWM
  always_ff @(posedge mclk) begin
    if (rst) begin
      hs1_reg <= 1'b0;
      hs2_reg <= 1'b0;
      hs3_reg <= 1'b0;
    end else begin
      hs1_reg <= cmd_reg[sbc_pkg::SBC_CMD_HS1] &
                 sync2_reg[sbc_pkg::SBC_SY_GATE];
      hs2_reg <= cmd_reg[sbc_pkg::SBC_CMD_HS2] &
                 sync2_reg[sbc_pkg::SBC_SY_GATE];
      hs3_reg <= cmd_reg[sbc_pkg::SBC_CMD_HS3];
    end
  end

  // LIN receive and transmit paths
  always_ff @(posedge mclk) begin
    if (rst) begin
      rxd_reg <= 1'b1;
      lin_oe_reg <= 1'b0;
    end else begin
      rxd_reg <= sync2_reg[sbc_pkg::SBC_SY_LIN];
      lin_oe_reg <= ~sync2_reg[sbc_pkg::SBC_SY_TXD];
    end
  end

  // Sense amplifier follows Normal mode
  always_ff @(posedge mclk) begin
    if (rst) begin
      amp_reg <= 1'b0;
    end else begin
      amp_reg <= in_normal;
    end
  end

  // Watchdog pin decoding
  always_ff @(posedge mclk) begin
    if (rst) begin
      wd_en_reg <= 1'b0;
      wd_def_reg <= 1'b0;
    end else begin
      // Grounded pin: no supervision
      wd_en_reg <= sync2_reg[sbc_pkg::SBC_SY_WDP];
      // Open pin with no resistor: default period
      wd_def_reg <= sync2_reg[sbc_pkg::SBC_SY_WDP] &
                    ~sync2_reg[sbc_pkg::SBC_SY_WDR];
    end
  end

  // Output wiring, each from a flop except the constant lin_bus_out
  assign miso = spi.miso;
  assign miso_oe = spi.miso_oe;
  assign high_side_out_one = hs1_reg;
  assign high_side_out_two = hs2_reg;
  assign high_side_out_three = hs3_reg;
  assign lin_bus_out = 1'b0; // Dominant level when enabled
  assign lin_bus_oe = lin_oe_reg;
  assign lin_rxd = rxd_reg;
  assign wake_req = wake_reg;
  assign int_n = int_n_reg;
  assign amp_en = amp_reg;
  assign wd_enable = wd_en_reg;
  assign wd_use_default = wd_def_reg;
endmodule : sbc_core
`default_nettype wire

// ### sbc_asserts.sv
// Port-level checks of the wake-up and serial control block
`timescale 1ns/1ps
`default_nettype none
module sbc_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic miso,
  input wire logic miso_oe,
  input wire sbc_pkg::sbc_mode_t mode,
  input wire logic level_input_one,
  input wire logic pwm_gate,
  input wire logic high_side_out_one,
  input wire logic high_side_out_two,
  input wire logic lin_bus_in,
  input wire logic lin_bus_out,
  input wire logic lin_bus_oe,
  input wire logic lin_txd,
  input wire logic lin_rxd,
  input wire logic wake_req,
  input wire logic int_n,
  input wire logic amp_en,
  input wire logic watchdog_period_pin,
  input wire logic watchdog_resistor_fitted,
  input wire logic wd_enable,
  input wire logic wd_use_default
);
  logic [2:0] up_reg; // Cycles since reset, saturating
  logic ok; // Pipelines refilled since reset
  // Count up after reset so history is clean
  always_ff @(posedge mclk) begin
    if (rst) up_reg <= 3'h0;
    else if (!ok) up_reg <= up_reg + 3'h1;
  end
  assign ok = (up_reg == 3'h7);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_MISO_OFF: assert property (
    cs_n && $past(cs_n) |-> !miso_oe && !miso)
    else $error("serial output active while deselected");
  AST_HS1_GATE: assert property (
    ok && high_side_out_one |-> $past(pwm_gate, 3) || $past(pwm_gate, 4))
    else $error("switch one on without gate");
  AST_HS2_GATE: assert property (
    ok && high_side_out_two |-> $past(pwm_gate, 3) || $past(pwm_gate, 4))
    else $error("switch two on without gate");
  AST_RXD: assert property (
    ok |-> lin_rxd == $past(lin_bus_in, 3))
    else $error("receive output does not follow bus");
  AST_TXD: assert property (
    ok |-> lin_bus_oe == !$past(lin_txd, 3) && !lin_bus_out)
    else $error("bus drive does not follow transmit input");
  AST_AMP: assert property (
    ok |-> amp_en == ($past(mode) == sbc_pkg::SBC_MODE_NORMAL))
    else $error("amplifier enable wrong for mode");
  AST_WD_EN: assert property (
    ok |-> wd_enable == $past(watchdog_period_pin, 3))
    else $error("watchdog enable wrong");
  AST_WD_DEF: assert property (
    ok |-> wd_use_default == ($past(watchdog_period_pin, 3)
      && !$past(watchdog_resistor_fitted, 3)))
    else $error("default period select wrong");
  AST_INT: assert property (
    $fell(int_n) |-> (mode == sbc_pkg::SBC_MODE_STOP) ##1 !int_n [*8])
    else $error("interrupt pulse wrong");
  AST_LVL_WAKE: assert property (
    ok && mode[1] && $changed(level_input_one) |-> ##[2:6] wake_req)
    else $error("level change gave no wake-up");
endmodule : sbc_asserts
`default_nettype wire

// ### sbc_spi_master.sv
// Serial master model standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module sbc_spi_master (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  output logic [7:0] rx_word,
  output logic done
);
  // Idle: deselected, clock parked high
  // Select rises after time zero so the shifter sees its clearing edge
  initial begin
    sclk = 1'b1;
    mosi = 1'b0;
    rx_word = 8'h00;
    done = 1'b0;
    #1;
    cs_n = 1'b1;
  end
  // One frame MSB first, cut short when nbits is below 8
  task automatic frame(input int nbits, input logic [7:0] tx);
    cs_n = 1'b0;
    #80;
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b0;
      mosi = tx[7 - i];
      #6;
      sclk = 1'b1;
      rx_word = {rx_word[6:0], miso_oe ? miso : 1'bx};
      #6;
    end
    #20;
    cs_n = 1'b1;
    mosi = ~mosi; // Released line shows the inverse
    done = (nbits == 8);
    #20;
    done = 1'b0;
    #100;
  endtask : frame
  // Clock and data wiggle while deselected
  task automatic noise();
    repeat (8) begin
      sclk = 1'b0;
      mosi = ~mosi;
      #6;
      sclk = 1'b1;
      #6;
    end
  endtask : noise
endmodule : sbc_spi_master
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the wake-up and serial control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk = 1'b0;
  logic rst, sclk, cs_n, mosi, miso, miso_oe, pwm_gate, done;
  logic level_input_one, level_input_two, lin_bus_in, lin_bus_out;
  logic high_side_out_one, high_side_out_two, high_side_out_three;
  logic lin_bus_oe, lin_txd, lin_rxd, wake_req, int_n, amp_en;
  logic watchdog_period_pin, watchdog_resistor_fitted;
  logic wd_enable, wd_use_default;
  logic [7:0] rx_word; // Word read back by the master
  logic [31:0] seed = 32'h0000CCD6; // Xorshift state
  logic [31:0] r; // Current random draw
  logic [7:0] exp_q[$]; // Expected status words, oldest first
  sbc_pkg::sbc_mode_t mode;
  int n_errors = 0;
  int check_count = 0;
  sbc_core i_sbc_core (
    .mclk(mclk),
    .rst(rst),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .miso(miso),
    .miso_oe(miso_oe),
    .mode(mode),
    .level_input_one(level_input_one),
    .level_input_two(level_input_two),
    .pwm_gate(pwm_gate),
    .high_side_out_one(high_side_out_one),
    .high_side_out_two(high_side_out_two),
    .high_side_out_three(high_side_out_three),
    .lin_bus_in(lin_bus_in),
    .lin_bus_out(lin_bus_out),
    .lin_bus_oe(lin_bus_oe),
    .lin_txd(lin_txd),
    .lin_rxd(lin_rxd),
    .wake_req(wake_req),
    .int_n(int_n),
    .amp_en(amp_en),
    .watchdog_period_pin(watchdog_period_pin),
    .watchdog_resistor_fitted(watchdog_resistor_fitted),
    .wd_enable(wd_enable),
    .wd_use_default(wd_use_default)
  );
  sbc_spi_master i_sbc_spi_master (
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .miso(miso),
    .miso_oe(miso_oe),
    .rx_word(rx_word),
    .done(done)
  );
  always #10 mclk = ~mclk;
  // Xorshift generator
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Switch outputs packed low
  function automatic logic [7:0] hs();
    return {5'h00, high_side_out_three, high_side_out_two, high_side_out_one};
  endfunction : hs
  // Level bits as the status word should show them
  function automatic logic [7:0] lv();
    return {6'h00, level_input_two, level_input_one};
  endfunction : lv
  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, seen, want);
    end
  endtask : check
  // Note the expected status, then run a whole word
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] st);
    exp_q.push_back(st);
    i_sbc_spi_master.frame(8, cmd);
    repeat (2) @(negedge mclk);
  endtask : xfer
  // Look for a wake pulse over a bounded span
  task automatic wake_in(input int lim, input logic want);
    logic seen;
    seen = 1'b0;
    repeat (lim) begin
      @(negedge mclk);
      seen |= (wake_req === 1'b1);
    end
    check({7'h00, seen}, {7'h00, want});
  endtask : wake_in
  // Verdict and end of run
  task automatic results();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  // Compare each read word with the oldest note
  always @(posedge done) begin
    if (exp_q.size() == 0) begin
      n_errors++;
      $display("BAD %0t word read with no expectation", $time);
    end else begin
      check(rx_word, exp_q.pop_front());
    end
  end
  // Hang guard
  initial begin
    #200000;
    n_errors++;
    results();
  end
  // Main sequence
  initial begin
    rst = 1'b0;
    mode = sbc_pkg::SBC_MODE_NORMAL;
    level_input_one = 1'b0;
    level_input_two = 1'b0;
    pwm_gate = 1'b1;
    lin_bus_in = 1'b1;
    lin_txd = 1'b1;
    watchdog_period_pin = 1'b1;
    watchdog_resistor_fitted = 1'b0;
    // Reset rises on a falling edge so the link flops see it
    @(negedge mclk);
    rst = 1'b1;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    // Random commands against random gate and pins
    repeat (8) begin
      r = rnd();
      {pwm_gate, lin_txd, level_input_one, level_input_two} = r[11:8];
      {watchdog_period_pin, watchdog_resistor_fitted} = r[13:12];
      repeat (5) @(negedge mclk);
      xfer(r[7:0], lv());
      check(hs(), {5'h00, r[2], r[1] & r[11], r[0] & r[11]});
    end
    pwm_gate = 1'b1;
    xfer(8'h07, lv());
    // Short frame, then activity while deselected
    i_sbc_spi_master.frame(5, 8'h00);
    i_sbc_spi_master.noise();
    @(negedge mclk);
    check(hs(), 8'h07);
    mode = sbc_pkg::SBC_MODE_RESET;
    repeat (3) @(negedge mclk);
    mode = sbc_pkg::SBC_MODE_SLEEP;
    repeat (3) @(negedge mclk);
    level_input_one = ~level_input_one;
    wake_in(8, 1'b1);
    xfer(8'h00, 8'h40);
    // Short then long dominant on the bus in Stop
    mode = sbc_pkg::SBC_MODE_STOP;
    lin_bus_in = 1'b0;
    repeat (200) @(negedge mclk);
    lin_bus_in = 1'b1;
    wake_in(20, 1'b0);
    lin_bus_in = 1'b0;
    repeat (1600) @(negedge mclk);
    lin_bus_in = 1'b1;
    wake_in(7, 1'b1);
    check({7'h00, int_n}, 8'h00);
    xfer(8'h00, 8'h80);
    results();
  end
endmodule : tb_top
bind sbc_core sbc_asserts i_sbc_asserts (
  .mclk(mclk),
  .rst(rst),
  .cs_n(cs_n),
  .miso(miso),
  .miso_oe(miso_oe),
  .mode(mode),
  .level_input_one(level_input_one),
  .pwm_gate(pwm_gate),
  .high_side_out_one(high_side_out_one),
  .high_side_out_two(high_side_out_two),
  .lin_bus_in(lin_bus_in),
  .lin_bus_out(lin_bus_out),
  .lin_bus_oe(lin_bus_oe),
  .lin_txd(lin_txd),
  .lin_rxd(lin_rxd),
  .wake_req(wake_req),
  .int_n(int_n),
  .amp_en(amp_en),
  .watchdog_period_pin(watchdog_period_pin),
  .watchdog_resistor_fitted(watchdog_resistor_fitted),
  .wd_enable(wd_enable),
  .wd_use_default(wd_use_default)
);
`default_nettype wire
